/* rtl/cfl_pkg.sv */
package cfl_pkg;

  // ----------------------------------------------------------------
  // Register map: word index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int APB_AW         = 8;
  localparam int IDX_CTRL       = 0;
  localparam int IDX_HYST_SEL   = 1;
  localparam int IDX_HYST_HI    = 2;
  localparam int IDX_HYST_LO    = 3;
  localparam int IDX_COND_SEL   = 4;
  localparam int IDX_COND_OP    = 5;
  localparam int IDX_SR_SEL     = 6;
  localparam int IDX_SR_SET_THR = 7;
  localparam int IDX_SR_RST_THR = 8;
  localparam int IDX_STATUS     = 9;
  localparam int IDX_HYST_VAL   = 10;
  localparam int CFG_NUM        = 9;
  localparam int REG_NUM        = 11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_W          = 8;
  localparam int CTRL_HYST_EN   = 0;
  localparam int CTRL_COND_EN   = 1;
  localparam int CTRL_SR_EN     = 2;
  localparam int HSEL_IN_LSB    = 0;
  localparam int HSEL_HIGH_LSB  = 8;
  localparam int HSEL_LOW_LSB   = 16;
  localparam int OP1_LSB        = 0;
  localparam int OP2_LSB        = 4;
  localparam int OP3_LSB        = 8;
  localparam int SRSEL_SET_LSB  = 0;
  localparam int SRSEL_RST_LSB  = 8;
  localparam int THR_MIN_LSB    = 0;
  localparam int THR_MAX_LSB    = 8;
  localparam int ST_HYST_HIGH   = 0;
  localparam int ST_COND        = 1;
  localparam int ST_SR_OUT      = 2;
  localparam int ST_SR_SET_ON   = 3;
  localparam int ST_SR_RST_ON   = 4;

  // ----------------------------------------------------------------
  // Write masks and reset values of the configuration words
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_MASK [0:CFG_NUM-1] = '{
    32'h0000_0007, 32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff, 32'hffff_ffff,
    32'h0000_03ff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
  localparam logic [31:0] CFG_RST [0:CFG_NUM-1] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0100, 32'h0000_0000, 32'h0000_4b19, 32'h0000_4b19};

  // ----------------------------------------------------------------
  // Evaluation rate
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int EVAL_PERIOD_NS = 1000;
  localparam int EVAL_CYCLES    = EVAL_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Operator codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CFL_OP_FALSE = 4'h0, CFL_OP_EQ  = 4'h1, CFL_OP_NE  = 4'h2, CFL_OP_GT = 4'h3,
    CFL_OP_GE    = 4'h4, CFL_OP_LT  = 4'h5, CFL_OP_LE  = 4'h6, CFL_OP_OR = 4'h7,
    CFL_OP_AND   = 4'h8, CFL_OP_XOR = 4'h9
  } cfl_cmp_op_t;

  typedef enum logic [1:0] {
    CFL_CB_FALSE = 2'h0, CFL_CB_OR = 2'h1, CFL_CB_AND = 2'h2, CFL_CB_XOR = 2'h3
  } cfl_comb_op_t;

  // Operand values travel zero-extended; codes 10 to 15 read as false
  function automatic logic cmp_eval(input logic [3:0] op, input logic [31:0] a,
                                    input logic [31:0] b);
    logic ta;
    logic tb;
    ta = |a;
    tb = |b;
    case (op)
      CFL_OP_EQ:  cmp_eval = (a == b);
      CFL_OP_NE:  cmp_eval = (a != b);
      CFL_OP_GT:  cmp_eval = (a > b);
      CFL_OP_GE:  cmp_eval = (a >= b);
      CFL_OP_LT:  cmp_eval = (a < b);
      CFL_OP_LE:  cmp_eval = (a <= b);
      CFL_OP_OR:  cmp_eval = ta | tb;
      CFL_OP_AND: cmp_eval = ta & tb;
      CFL_OP_XOR: cmp_eval = ta ^ tb;
      default:    cmp_eval = 1'b0;
    endcase
  endfunction

  function automatic logic comb_eval(input logic [1:0] op, input logic r1, input logic r2);
    case (op)
      CFL_CB_OR:  comb_eval = r1 | r2;
      CFL_CB_AND: comb_eval = r1 & r2;
      CFL_CB_XOR: comb_eval = r1 ^ r2;
      default:    comb_eval = 1'b0;
    endcase
  endfunction

endpackage

/* rtl/cfl_sr_if.sv */
interface cfl_sr_if #(parameter int DATA_W = 16);
  logic [DATA_W-1:0] set_val;
  logic [DATA_W-1:0] rst_val;
  logic [7:0]        set_min;
  logic [7:0]        set_max;
  logic [7:0]        rst_min;
  logic [7:0]        rst_max;
  logic              tick;
  logic              set_on;
  logic              rst_on;
  logic              q;

  modport ctl   (output set_val, rst_val, set_min, set_max, rst_min, rst_max, tick,
                 input  set_on, rst_on, q);
  modport latch (input  set_val, rst_val, set_min, set_max, rst_min, rst_max, tick,
                 output set_on, rst_on, q);
endinterface

/* rtl/cfl_sr_latch.sv */
module cfl_sr_latch #(
  parameter int DATA_W     = 16,
  parameter int FULL_SCALE = 65535
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Latch side of the link to the main block
  cfl_sr_if.latch   sr
);

  localparam int PW = DATA_W + 8;

  logic set_on_reg;
  logic rst_on_reg;
  logic q_reg;
  logic set_on_next;
  logic rst_on_next;

  // Percent thresholds compared without division: val*100 against pct*full
  function automatic logic level_next(input logic [DATA_W-1:0] val, input logic [7:0] mn,
                                      input logic [7:0] mx, input logic cur);
    logic [PW-1:0] v100;
    v100 = PW'(val) * PW'(100);
    // Off wins when a bad setting makes both limits true
    if (v100 <= PW'(mn) * PW'(FULL_SCALE))
      level_next = 1'b0;
    else if (v100 >= PW'(mx) * PW'(FULL_SCALE))
      level_next = 1'b1;
    else
      level_next = cur;
  endfunction

  always_comb begin
    set_on_next = level_next(sr.set_val, sr.set_min, sr.set_max, set_on_reg);
    rst_on_next = level_next(sr.rst_val, sr.rst_min, sr.rst_max, rst_on_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_on_reg <= 1'b0;
      rst_on_reg <= 1'b0;
    end else if (sr.tick) begin
      set_on_reg <= set_on_next;
      rst_on_reg <= rst_on_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 1'b0;
    end else if (sr.tick) begin
      if (rst_on_next)
        q_reg <= 1'b0;
      else if (set_on_next)
        q_reg <= 1'b1;
      else
        q_reg <= q_reg;
    end
  end

  assign sr.set_on = set_on_reg;
  assign sr.rst_on = rst_on_reg;
  assign sr.q      = q_reg;

endmodule

/* rtl/cfl_logic_blocks.sv */
// Overview of operation
// - Hysteresis input above high threshold: output follows high-output source.
// - Hysteresis input below low threshold: output follows low-output source.
// - Conditional block result is only zero or one.
// - First operator uses inputs one and two, second uses three and four.
// - Codes 0..6: false, =, !=, >, >=, <, <= of A against B.
// - Codes 7, 8, 9: OR, AND, XOR of A and B as truth values.
// - Third operator: 0 false, 1 OR, 2 AND, 3 XOR of both results.
// - Reset input on forces the latch output off.
// - Set on with reset off turns the latch output on.
// - Both off: latch holds its last output.
// - Set and reset levels come from percent min/max limits with dead band.
//
// Added by the designer: the APB register port and the address map.
module cfl_logic_blocks #(
  parameter int DATA_W     = 16,
  parameter int N_SRC      = 8,
  parameter int FULL_SCALE = (1 << DATA_W) - 1
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic [cfl_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Signals from other function blocks, source n at slice n-1
  input  wire logic [N_SRC*DATA_W-1:0]   src_bus,
  // Block results
  output logic [DATA_W-1:0]              hyst_out,
  output logic                           cond_out,
  output logic                           sr_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DATA_W < 2 || DATA_W > 24 || N_SRC < 1 || N_SRC > 255 ||
      FULL_SCALE < 1 || FULL_SCALE >= (1 << DATA_W)) begin : g_bad_param
    $error("cfl_logic_blocks: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]        cfg_reg [0:cfl_pkg::CFG_NUM-1];
  logic [5:0]         idx;
  logic               access;
  logic               hi_sel_reg;
  logic               hi_sel_next;
  logic [DATA_W-1:0]  hyst_out_reg;
  logic               cond_out_reg;
  logic [7:0]         tick_cnt_reg;
  logic               tick;
  cfl_sr_if #(.DATA_W(DATA_W)) sr_link ();

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        res[b*8 +: 8] = wd[b*8 +: 8];
    end
    strb_merge = res;
  endfunction

  assign idx    = paddr[cfl_pkg::APB_AW-1:2];
  assign access = psel && penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && ((idx >= 6'(cfl_pkg::REG_NUM)) ||
                              (pwrite && idx >= 6'(cfl_pkg::CFG_NUM)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < cfl_pkg::CFG_NUM; i++)
        cfg_reg[i] <= cfl_pkg::CFG_RST[i];
    end else if (access && pwrite) begin
      for (int i = 0; i < cfl_pkg::CFG_NUM; i++) begin
        if (idx == 6'(i))
          cfg_reg[i] <= strb_merge(cfg_reg[i], pwdata, pstrb) & cfl_pkg::CFG_MASK[i];
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (idx < 6'(cfl_pkg::CFG_NUM))
        prdata = cfg_reg[idx[3:0]];
      else if (idx == 6'(cfl_pkg::IDX_STATUS)) begin
        prdata[cfl_pkg::ST_HYST_HIGH] = hi_sel_reg;
        prdata[cfl_pkg::ST_COND]      = cond_out_reg;
        prdata[cfl_pkg::ST_SR_OUT]    = sr_link.q;
        prdata[cfl_pkg::ST_SR_SET_ON] = sr_link.set_on;
        prdata[cfl_pkg::ST_SR_RST_ON] = sr_link.rst_on;
      end else if (idx == 6'(cfl_pkg::IDX_HYST_VAL))
        prdata[DATA_W-1:0] = hyst_out_reg;
    end
  end

  // ----------------------------------------------------------------
  // Evaluation tick
  // ----------------------------------------------------------------
  // Blocks update at a fixed period so chained sources settle like a scan loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt_reg <= 8'h00;
    else if (tick)
      tick_cnt_reg <= 8'(cfl_pkg::EVAL_CYCLES - 1);
    else
      tick_cnt_reg <= tick_cnt_reg - 8'h01;
  end
  assign tick = (tick_cnt_reg == 8'h00);

  // ----------------------------------------------------------------
  // Source selection: 0 and numbers past the last source read as zero
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] pick(input logic [7:0] sel);
    int base;
    base = 0;
    pick = '0;
    if (sel != 8'h00 && int'(sel) <= N_SRC) begin
      base = (int'(sel) - 1) * DATA_W;
      pick = src_bus[base +: DATA_W];
    end
  endfunction

  function automatic logic [7:0] sel_field(input logic [31:0] word, input int lsb);
    sel_field = word[lsb +: cfl_pkg::SEL_W];
  endfunction

  // ----------------------------------------------------------------
  // Hysteresis block
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] hyst_in;
  logic [DATA_W-1:0] hyst_hi;
  logic [DATA_W-1:0] hyst_lo;

  always_comb begin
    hyst_in = pick(sel_field(cfg_reg[cfl_pkg::IDX_HYST_SEL], cfl_pkg::HSEL_IN_LSB));
    hyst_hi = cfg_reg[cfl_pkg::IDX_HYST_HI][DATA_W-1:0];
    hyst_lo = cfg_reg[cfl_pkg::IDX_HYST_LO][DATA_W-1:0];
    if (hyst_in > hyst_hi)
      hi_sel_next = 1'b1;
    else if (hyst_in < hyst_lo)
      hi_sel_next = 1'b0;
    else
      hi_sel_next = hi_sel_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_sel_reg   <= 1'b0;
      hyst_out_reg <= '0;
    end else if (tick && cfg_reg[cfl_pkg::IDX_CTRL][cfl_pkg::CTRL_HYST_EN]) begin
      hi_sel_reg <= hi_sel_next;
      // Chosen source is re-read every tick, so the output tracks its value
      if (hi_sel_next)
        hyst_out_reg <= pick(sel_field(cfg_reg[cfl_pkg::IDX_HYST_SEL],
                                       cfl_pkg::HSEL_HIGH_LSB));
      else
        hyst_out_reg <= pick(sel_field(cfg_reg[cfl_pkg::IDX_HYST_SEL],
                                       cfl_pkg::HSEL_LOW_LSB));
    end
  end

  // ----------------------------------------------------------------
  // Conditional logic block
  // ----------------------------------------------------------------
  logic [31:0] cin [0:3];
  logic        first_result;
  logic        second_result;
  logic        cond_next;

  always_comb begin
    for (int i = 0; i < 4; i++)
      cin[i] = 32'(pick(sel_field(cfg_reg[cfl_pkg::IDX_COND_SEL], i * cfl_pkg::SEL_W)));
    first_result  = cfl_pkg::cmp_eval(cfg_reg[cfl_pkg::IDX_COND_OP][cfl_pkg::OP1_LSB +: 4],
                                      cin[0], cin[1]);
    second_result = cfl_pkg::cmp_eval(cfg_reg[cfl_pkg::IDX_COND_OP][cfl_pkg::OP2_LSB +: 4],
                                      cin[2], cin[3]);
    // Unused second operator yields false, so OR passes the first alone
    cond_next = cfl_pkg::comb_eval(cfg_reg[cfl_pkg::IDX_COND_OP][cfl_pkg::OP3_LSB +: 2],
                                   first_result, second_result);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cond_out_reg <= 1'b0;
    else if (tick && cfg_reg[cfl_pkg::IDX_CTRL][cfl_pkg::CTRL_COND_EN])
      cond_out_reg <= cond_next;
  end

  // ----------------------------------------------------------------
  // Set-reset block
  // ----------------------------------------------------------------
  // Inside a process so that a change of the selected source value is seen
  always_comb begin
    sr_link.set_val = pick(sel_field(cfg_reg[cfl_pkg::IDX_SR_SEL], cfl_pkg::SRSEL_SET_LSB));
    sr_link.rst_val = pick(sel_field(cfg_reg[cfl_pkg::IDX_SR_SEL], cfl_pkg::SRSEL_RST_LSB));
  end
  assign sr_link.set_min = cfg_reg[cfl_pkg::IDX_SR_SET_THR][cfl_pkg::THR_MIN_LSB +: 8];
  assign sr_link.set_max = cfg_reg[cfl_pkg::IDX_SR_SET_THR][cfl_pkg::THR_MAX_LSB +: 8];
  assign sr_link.rst_min = cfg_reg[cfl_pkg::IDX_SR_RST_THR][cfl_pkg::THR_MIN_LSB +: 8];
  assign sr_link.rst_max = cfg_reg[cfl_pkg::IDX_SR_RST_THR][cfl_pkg::THR_MAX_LSB +: 8];
  assign sr_link.tick    = tick && cfg_reg[cfl_pkg::IDX_CTRL][cfl_pkg::CTRL_SR_EN];

  cfl_sr_latch #(
    .DATA_W     (DATA_W),
    .FULL_SCALE (FULL_SCALE)
  ) u_sr (
    .pclk    (pclk),
    .presetn (presetn),
    .sr      (sr_link.latch)
  );

  assign hyst_out = hyst_out_reg;
  assign cond_out = cond_out_reg;
  assign sr_out   = sr_link.q;

endmodule

/* tb/cfl_src_model.sv */
module cfl_src_model #(
  parameter int DATA_W = 16,
  parameter int N_SRC  = 8
) (
  // Values offered to the block
  output logic [N_SRC*DATA_W-1:0] src_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // One independent value per source
  // ----------------------------------------------------------------
  logic [N_SRC:1][DATA_W-1:0] val_reg = '0;
  assign src_bus = val_reg;
  // Caller invokes this just after an edge so the block never sees a race
  task automatic put(input int n, input logic [DATA_W-1:0] v);
    val_reg[n] <= v;
  endtask
endmodule

/* tb/cfl_logic_blocks_asserts.sv */
module cfl_logic_blocks_asserts #(
  parameter int DATA_W     = 16,
  parameter int N_SRC      = 8,
  parameter int FULL_SCALE = 65535
) (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB slave
  input wire logic [cfl_pkg::APB_AW-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic                       pready,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  // Function link
  input wire logic [N_SRC*DATA_W-1:0]    src_bus,
  input wire logic [DATA_W-1:0]          hyst_out,
  input wire logic                       cond_out,
  input wire logic                       sr_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [DATA_W+1:0] last_reg;
  logic [7:0]        quiet_reg;
  logic [1:0]        since_reg;
  logic [5:0]        idx;
  logic              chg;
  assign idx = paddr[7:2];
  assign chg = {hyst_out, cond_out, sr_out} != last_reg;
  // Results may move only once per evaluation period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= '0;
      quiet_reg <= 8'hff;
    end else begin
      last_reg <= {hyst_out, cond_out, sr_out};
      quiet_reg <= chg ? 8'h00 : quiet_reg + {7'h0, quiet_reg != 8'hff};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_reg <= 2'h0;
    end else begin
      since_reg <= since_reg + {1'b0, since_reg != 2'h3};
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  rd_idle_a: assert property (!psel || pwrite |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  err_unmap_a: assert property (psel && penable && idx >= 6'd11 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_ro_a: assert property (psel && penable && pwrite && idx inside {6'd9, 6'd10} |-> pslverr)
    else $error("write to read-only word not refused");
  err_none_a: assert property (psel && penable && idx < 6'd9 |-> !pslverr)
    else $error("error on a mapped word");
  out_hold_a: assert property (chg |-> quiet_reg >= 8'd248)
    else $error("result moved between evaluations");
  rst_zero_a: assert property (since_reg < 2'h2 |-> {hyst_out, cond_out, sr_out} == '0)
    else $error("results not off after reset");
  stat_mirror_a: assert property (psel && !pwrite && idx == 6'd9 |->
    prdata[2:1] == {sr_out, cond_out} && prdata[31:5] == 27'h0)
    else $error("status disagrees with outputs");
  hval_mirror_a: assert property (psel && !pwrite && idx == 6'd10 |->
    prdata == {{(32-DATA_W){1'b0}}, hyst_out})
    else $error("hysteresis value word disagrees");
  cover property ($rose(sr_out));
  cover property ($rose(cond_out));
  cover property ($changed(hyst_out));
endmodule

bind cfl_logic_blocks cfl_logic_blocks_asserts #(
  .DATA_W(DATA_W), .N_SRC(N_SRC), .FULL_SCALE(FULL_SCALE)
) chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .src_bus(src_bus), .hyst_out(hyst_out), .cond_out(cond_out),
  .sr_out(sr_out)
);

/* tb/configurable_logic_blocks_tb_top.sv */
module configurable_logic_blocks_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [9:0]  op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
    logic        e;
  } cfl_row_t;
  // Single compares use op2 false and op3 OR
  localparam cfl_row_t ROWS [20] = '{
    '{10'h100, 16'h5, 16'h5, 16'h0, 16'h0, 1'h0}, '{10'h101, 16'h5, 16'h5, 16'h0, 16'h0, 1'h1},
    '{10'h101, 16'h5, 16'h6, 16'h0, 16'h0, 1'h0}, '{10'h102, 16'h5, 16'h6, 16'h0, 16'h0, 1'h1},
    '{10'h103, 16'hffff, 16'hfffe, 16'h0, 16'h0, 1'h1},
    '{10'h103, 16'h5, 16'h5, 16'h0, 16'h0, 1'h0},
    '{10'h104, 16'h5, 16'h5, 16'h0, 16'h0, 1'h1}, '{10'h105, 16'h5, 16'h5, 16'h0, 16'h0, 1'h0},
    '{10'h105, 16'h4, 16'h5, 16'h0, 16'h0, 1'h1}, '{10'h106, 16'h5, 16'h5, 16'h0, 16'h0, 1'h1},
    '{10'h107, 16'h0, 16'h3, 16'h0, 16'h0, 1'h1}, '{10'h107, 16'h0, 16'h0, 16'h0, 16'h0, 1'h0},
    '{10'h108, 16'h2, 16'h0, 16'h0, 16'h0, 1'h0}, '{10'h108, 16'h2, 16'h9, 16'h0, 16'h0, 1'h1},
    '{10'h109, 16'h1, 16'h1, 16'h0, 16'h0, 1'h0}, '{10'h109, 16'h0, 16'h7, 16'h0, 16'h0, 1'h1},
    '{10'h011, 16'h1, 16'h1, 16'h2, 16'h2, 1'h0}, '{10'h211, 16'h1, 16'h1, 16'h2, 16'h3, 1'h0},
    '{10'h211, 16'h1, 16'h1, 16'h2, 16'h2, 1'h1}, '{10'h311, 16'h1, 16'h1, 16'h2, 16'h2, 1'h0}};
  // Input steps across 500 and 1000, strict compares at the edges
  localparam logic [15:0] HIN [8] = '{16'h64, 16'h2bc, 16'h3e9, 16'h2bc, 16'h3e8, 16'h1f4,
                                      16'h1f3, 16'h3e8};
  localparam logic [15:0] HEX [8] = '{16'h5555, 16'h5555, 16'haaaa, 16'haaaa, 16'haaaa,
                                      16'haaaa, 16'h5555, 16'h5555};
  // Set value, reset value, latch; 25 and 75 percent edges sit at 3fff/4000 and bfff/c000
  localparam logic [32:0] SRS [9] = '{{16'hffff, 16'h0, 1'h1}, {16'h0, 16'h0, 1'h1},
    {16'hffff, 16'hffff, 1'h0}, {16'hffff, 16'h8000, 1'h0}, {16'hffff, 16'h4000, 1'h0},
    {16'hffff, 16'h3fff, 1'h1}, {16'h0, 16'h0, 1'h1}, {16'h0, 16'hc000, 1'h0},
    {16'hffff, 16'hbfff, 1'h0}};
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic [3:0]   pstrb = 4'hf;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic [127:0] src_bus;
  logic [15:0]  hyst_out;
  logic         cond_out;
  logic         sr_out;
  logic [31:0]  rdv;
  logic         erv;
  int           miscompares = 0;
  int           cmp_count = 0;
  always #2 pclk = ~pclk;
  cfl_src_model src (.src_bus(src_bus));
  cfl_logic_blocks uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .src_bus(src_bus), .hyst_out(hyst_out), .cond_out(cond_out),
    .sr_out(sr_out)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer read where settled; the next rising edge completes the access
    for (n = 0; n < 40; n++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (n == 40) begin
      miscompares++;
      conclude();
    end
    rdv = prdata;
    erv = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One evaluation period plus margin
  task automatic settle();
    repeat (cfl_pkg::EVAL_CYCLES + 10) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
    apb(1'b1, 8'h10, 32'h0403_0201, 4'hf);
    for (int i = 0; i < 20; i++) begin
      src.put(1, ROWS[i].a);
      src.put(2, ROWS[i].b);
      src.put(3, ROWS[i].c);
      src.put(4, ROWS[i].d);
      apb(1'b1, 8'h14, {22'h0, ROWS[i].op}, 4'hf);
      settle();
      chk({31'h0, cond_out}, {31'h0, ROWS[i].e}, "cond row");
    end
    $display("conditional table done");
    src.put(6, 16'haaaa);
    src.put(7, 16'h5555);
    apb(1'b1, 8'h04, 32'h0007_0605, 4'hf);
    apb(1'b1, 8'h08, 32'h0000_03e8, 4'hf);
    apb(1'b1, 8'h0c, 32'h0000_01f4, 4'hf);
    for (int i = 0; i < 8; i++) begin
      src.put(5, HIN[i]);
      settle();
      chk({16'h0, hyst_out}, {16'h0, HEX[i]}, "hysteresis step");
      apb(1'b0, 8'h24, 32'h0, 4'hf);
      chk({31'h0, rdv[0]}, {31'h0, HEX[i] == 16'haaaa}, "high selected");
    end
    $display("hysteresis done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({14'h0, hyst_out, cond_out, sr_out}, 32'h0, "outputs in reset");
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rdv, 32'h0, "ctrl reset");
    apb(1'b0, 8'h14, 32'h0, 4'hf);
    chk(rdv, 32'h0000_0100, "op reset");
    apb(1'b0, 8'h1c, 32'h0, 4'hf);
    chk(rdv, 32'h0000_4b19, "threshold reset");
    apb(1'b1, 8'h08, 32'hffff_ffff, 4'h2);
    apb(1'b0, 8'h08, 32'h0, 4'hf);
    chk(rdv, 32'h0000_ff00, "byte enable");
    apb(1'b0, 8'h30, 32'h0, 4'hf);
    chk({rdv[30:0], erv}, 32'h1, "unmapped read");
    apb(1'b1, 8'h24, 32'hffff_ffff, 4'hf);
    chk({31'h0, erv}, 32'h1, "status write");
    apb(1'b0, 8'h28, 32'h0, 4'hf);
    chk({rdv[30:0], erv}, 32'h0, "value read");
    $display("reset and bus done");
    src.put(8, 16'h0);
    src.put(4, 16'h0);
    apb(1'b1, 8'h18, 32'h0000_0408, 4'hf);
    apb(1'b1, 8'h00, 32'h0000_0007, 4'hf);
    settle();
    chk({31'h0, sr_out}, 32'h0, "latch start");
    for (int i = 0; i < 9; i++) begin
      src.put(8, SRS[i][32:17]);
      src.put(4, SRS[i][16:1]);
      settle();
      apb(1'b0, 8'h24, 32'h0, 4'hf);
      chk({31'h0, sr_out}, {31'h0, SRS[i][0]}, "latch step");
      chk({31'h0, rdv[2]}, {31'h0, SRS[i][0]}, "latch status");
    end
    $display("set-reset done");
    conclude();
  end
endmodule
